// file: include/amp_fault_pkg.sv
// constants and types shared by the amplifier fault-reporting block
package amp_fault_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ        = 200_000_000;
   localparam int unsigned SD_TO_RESET_MIN_MS = 4;
   // least time is not rounded up, the per-ms count truncates; 800000 cycles at 200 MHz
   localparam int unsigned SD_TO_RESET_CYCLES =
      (CLK_FREQ_HZ / 1000 * SD_TO_RESET_MIN_MS + 0) ;

   // ----------------------------------------------------------------
   // register map (axi4-lite byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_INPUTS  = 8'h08;

   // control fields
   localparam int unsigned CTRL_MODE_LSB  = 0;
   localparam int unsigned CTRL_SMALL_PKG = 2;
   localparam int unsigned CTRL_RUN       = 3;
   localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

   // status fields
   localparam int unsigned ST_OTE_LATCH   = 0;
   localparam int unsigned ST_OLP_LATCH   = 1;
   localparam int unsigned ST_UV          = 2;
   localparam int unsigned ST_SHUTDOWN    = 3;
   localparam int unsigned ST_HIZ_LSB     = 4;
   localparam int unsigned ST_GAP_DONE    = 8;
   localparam int unsigned ST_RESET_LOW   = 9;

   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // output configuration
   typedef enum logic [1:0] {
      bridge_tied_mode,
      parallel_bridge_mode,
      single_ended_mode,
      mode_reserved
   } out_mode_e;

endpackage

// file: rtl/amp_flag_sync.sv
// two-stage synchroniser for a bank of asynchronous fault levels
`timescale 1ns/1ps
module amp_flag_sync #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] raw,
   output logic      [WIDTH-1:0] synced
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_synced;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_meta   = meta;
      next_synced = synced;
      if (!aresetn) begin
         next_meta   = '0;
         next_synced = '0;
      end else if (ce) begin
         next_meta   = raw;
         next_synced = meta;   // first stage feeds only this flop
      end
   end

   // registers only
   always_ff @(posedge aclk) begin
      meta   <= next_meta;
      synced <= next_synced;
   end

endmodule // amp_flag_sync

// file: rtl/amp_fault_reporting.sv
// fault protection and error reporting of a four half-bridge power stage
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module amp_fault_reporting
   import amp_fault_pkg::*;
#(
   parameter int unsigned SD_GAP_CYCLES = amp_fault_pkg::SD_TO_RESET_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // device reset pin and fault levels
   input  wire logic        reset_pin_n,
   input  wire logic        gate_drive_supply_ok,
   input  wire logic        common_supply_ok,
   input  wire logic        temp_above_low,
   input  wire logic        temp_above_high,
   input  wire logic        overtemp_error,
   input  wire logic [3:0]  overload_fault,
   // open-drain flags: pin driven low while oe high
   output logic             shutdown_fault_n_o,
   output logic             shutdown_fault_n_oe,
   output logic             temp_warning_low_n_o,
   output logic             temp_warning_low_n_oe,
   output logic             temp_warning_high_n_o,
   output logic             temp_warning_high_n_oe,
   output logic             temp_warning_n_o,
   output logic             temp_warning_n_oe,
   // power stage
   output logic [3:0]       bridge_hiz,
   output logic [3:0]       bridge_pulldown,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ----------------------------------------------------------------
   // input sampling
   // ----------------------------------------------------------------
   localparam int unsigned NSYNC = 10;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync_in;

   assign raw_in = {overload_fault, overtemp_error, temp_above_high, temp_above_low,
                    common_supply_ok, gate_drive_supply_ok, reset_pin_n};

   // levels enter through a synchroniser bank
   amp_flag_sync #(.WIDTH(NSYNC)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .raw     (raw_in),
      .synced  (sync_in)
   );

   logic       rst_pin_n_s;
   logic       supplies_ok;
   logic       warn_low;
   logic       warn_high;
   logic       ote_s;
   logic [3:0] olp_s;

   assign rst_pin_n_s = sync_in[0];
   assign supplies_ok = sync_in[1] & sync_in[2];
   assign warn_low    = sync_in[3];
   assign warn_high   = sync_in[4];
   assign ote_s       = sync_in[5];
   assign olp_s       = sync_in[9:6];

   // ----------------------------------------------------------------
   // mode grouping of local errors
   // ----------------------------------------------------------------
   function automatic logic [3:0] group_off(input logic [3:0] err, input out_mode_e m);
      logic [3:0] r;
      r = '0;
      if (m == parallel_bridge_mode) begin
         r = {4{|err}};
      end else begin
         r[1:0] = {2{err[0] | err[1]}};
         r[3:2] = {2{err[2] | err[3]}};
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // control register and fault state
   // ----------------------------------------------------------------
   logic [31:0] control;
   logic        ote_latch;
   logic [3:0]  olp_latch;
   logic        rst_pin_d;
   logic [19:0] gap_cnt;
   logic        gap_done;
   logic        sd_low_q;

   logic        next_ote_latch;
   logic [3:0]  next_olp_latch;
   logic        next_rst_pin_d;
   logic [19:0] next_gap_cnt;
   logic        next_gap_done;

   out_mode_e   mode;
   logic        run_en;
   logic        reset_rise;
   logic        fault_any;
   logic [3:0]  hiz_now;
   logic [3:0]  olp_held;

   assign mode       = out_mode_e'(control[CTRL_MODE_LSB +: 2]);
   assign run_en     = control[CTRL_RUN];
   assign reset_rise = rst_pin_n_s & ~rst_pin_d;
   // latch is treated as gone on the rise itself, so no one-cycle false shutdown
   assign olp_held   = reset_rise ? 4'h0 : olp_latch;
   assign fault_any  = ote_latch | (|olp_held) | ~supplies_ok;

   // high impedance: reset, supply loss, latched fault, run bit clear or local group
   always_comb begin
      hiz_now = group_off(olp_held, mode);
      if (!rst_pin_n_s || !supplies_ok || ote_latch || !run_en) begin
         hiz_now = 4'hf;
      end
   end

   // fault latches and shutdown-gap counter
   always_comb begin
      next_ote_latch = ote_latch;
      next_olp_latch = olp_latch;
      next_rst_pin_d = rst_pin_d;
      next_gap_cnt   = gap_cnt;
      next_gap_done  = gap_done;
      if (!aresetn) begin
         next_ote_latch = 1'b0;
         next_olp_latch = '0;
         next_rst_pin_d = 1'b0;
         next_gap_cnt   = '0;
         next_gap_done  = 1'b0;
      end else if (ce) begin
         next_rst_pin_d = rst_pin_n_s;
         // reset low clears the thermal latch; event only sets it while reset is high
         if (!rst_pin_n_s) begin
            next_ote_latch = 1'b0;
         end
         if (ote_s && rst_pin_n_s) begin
            next_ote_latch = 1'b1;
         end
         // overload only released on reset rising edge
         if (reset_rise) begin
            next_olp_latch = '0;
         end
         next_olp_latch = next_olp_latch | (olp_s & {4{rst_pin_n_s}});
         // time since shutdown fell, so software can see when reset may rise
         if (!sd_low_q) begin
            next_gap_cnt  = '0;
            next_gap_done = 1'b0;
         end else if (gap_cnt >= 20'(SD_GAP_CYCLES - 1)) begin
            next_gap_done = 1'b1;
         end else begin
            next_gap_cnt = gap_cnt + 20'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      ote_latch <= next_ote_latch;
      olp_latch <= next_olp_latch;
      rst_pin_d <= next_rst_pin_d;
      gap_cnt   <= next_gap_cnt;
      gap_done  <= next_gap_done;
   end

   // ----------------------------------------------------------------
   // registered outputs toward the pins
   // ----------------------------------------------------------------
   logic       next_sd_low;
   logic       next_wl_low;
   logic       next_wh_low;
   logic [3:0] next_hiz;
   logic [3:0] next_pd;
   logic       next_ws_low;

   always_comb begin
      next_sd_low = sd_low_q;
      next_wl_low = temp_warning_low_n_oe;
      next_wh_low = temp_warning_high_n_oe;
      next_ws_low = temp_warning_n_oe;
      next_hiz    = bridge_hiz;
      next_pd     = bridge_pulldown;
      if (!aresetn) begin
         next_sd_low = 1'b0;
         next_wl_low = 1'b0;
         next_wh_low = 1'b0;
         next_ws_low = 1'b0;
         next_hiz    = 4'hf;
         next_pd     = 4'h0;
      end else if (ce) begin
         next_sd_low = fault_any & rst_pin_n_s;
         // both warnings (the single flag in the small package) also pulled on shutdown-class temperature error
         // package choice folded in here so a frozen clock enable holds every flag
         next_wh_low = (warn_high | ote_latch) & ~control[CTRL_SMALL_PKG];
         next_wl_low = (warn_low | warn_high | ote_latch) & ~control[CTRL_SMALL_PKG];
         next_ws_low = (warn_high | ote_latch) & control[CTRL_SMALL_PKG];
         next_hiz    = hiz_now;
         // no pulldown in single-ended mode
         next_pd     = (!rst_pin_n_s && mode != single_ended_mode) ? 4'hf : 4'h0;
      end
   end

   always_ff @(posedge aclk) begin
      sd_low_q        <= next_sd_low;
      bridge_hiz      <= next_hiz;
      bridge_pulldown <= next_pd;
   end

   // open-drain: value always 0, enable pulls low; pullup releases high
   always_ff @(posedge aclk) begin
      shutdown_fault_n_o     <= 1'b0;
      temp_warning_low_n_o   <= 1'b0;
      temp_warning_high_n_o  <= 1'b0;
      temp_warning_n_o       <= 1'b0;
      shutdown_fault_n_oe    <= next_sd_low;
      temp_warning_low_n_oe  <= next_wl_low;
      temp_warning_high_n_oe <= next_wh_low;
      temp_warning_n_oe      <= next_ws_low;
   end

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   logic        aw_got, w_got;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_got, next_w_got, next_bvalid, next_rvalid;
   logic [7:0]  next_aw_addr;
   logic [31:0] next_w_data, next_control, next_rdata;
   logic [3:0]  next_w_strb;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] status_word;

   assign status_word = {22'h0, ~rst_pin_n_s, gap_done, bridge_hiz,
                         sd_low_q, ~supplies_ok, |olp_latch, ote_latch};

   always_comb begin
      next_aw_got  = aw_got;
      next_w_got   = w_got;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      next_control = control;
      if (!aresetn) begin
         next_aw_got  = 1'b0;
         next_w_got   = 1'b0;
         next_aw_addr = '0;
         next_w_data  = '0;
         next_w_strb  = '0;
         next_bvalid  = 1'b0;
         next_bresp   = RESP_OKAY;
         next_rvalid  = 1'b0;
         next_rdata   = '0;
         next_rresp   = RESP_OKAY;
         next_control = CTRL_RESET_VAL;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            next_aw_got  = 1'b1;
            next_aw_addr = s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            next_w_got  = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
         end
         // write commits once both halves are held
         if (aw_got && w_got && !s_axi_bvalid) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = RESP_SLVERR;
            if (aw_addr == ADDR_CONTROL) begin
               next_bresp = RESP_OKAY;
               for (int i = 0; i < 4; i++) begin
                  if (w_strb[i]) begin
                     next_control[i*8 +: 8] = w_data[i*8 +: 8];
                  end
               end
            end else if (aw_addr == ADDR_STATUS || aw_addr == ADDR_INPUTS) begin
               next_bresp = RESP_OKAY;              // read-only, write ignored
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
               ADDR_CONTROL: next_rdata = control;
               ADDR_STATUS:  next_rdata = status_word;
               ADDR_INPUTS:  next_rdata = {22'h0, sync_in};
               default: begin
                  next_rdata = '0;
                  next_rresp = RESP_SLVERR;
               end
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      control       <= next_control;
      // ready flags registered; one item held per channel
      s_axi_awready <= aresetn & ~next_aw_got;
      s_axi_wready  <= aresetn & ~next_w_got;
      s_axi_arready <= aresetn & ~next_rvalid;
   end

endmodule // amp_fault_reporting

// file: tb/amp_fault_reporting_assertions.sv
// concurrent checks on the fault-reporting block's ports
`timescale 1ns/1ps
module amp_fault_reporting_assertions (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        reset_pin_n,
   input wire logic        gate_drive_supply_ok,
   input wire logic        common_supply_ok,
   input wire logic        temp_above_low,
   input wire logic        temp_above_high,
   input wire logic        overtemp_error,
   input wire logic [3:0]  overload_fault,
   input wire logic        shutdown_fault_n_oe,
   input wire logic        temp_warning_low_n_oe,
   input wire logic        temp_warning_high_n_oe,
   input wire logic        temp_warning_n_oe,
   input wire logic [3:0]  bridge_hiz,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ------------------------------------------------------------
   // fault pins; windows of 5 cover the 3-edge input latency
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_uv_hiz:
      assert property ((!gate_drive_supply_ok || !common_supply_ok) [*5] |-> bridge_hiz == 4'hf)
      else $error("stage switching with a supply low");
   a_uv_shutdown:
      assert property ((reset_pin_n && !common_supply_ok) [*5] |-> shutdown_fault_n_oe)
      else $error("shutdown flag released during undervoltage");
   a_sd_in_reset:
      assert property (!reset_pin_n [*5] |-> !shutdown_fault_n_oe)
      else $error("shutdown flag pulled low while reset pin low");
   a_warn_high:
      assert property (temp_above_high [*5]
                       |-> temp_warning_n_oe || (temp_warning_high_n_oe && temp_warning_low_n_oe))
      else $error("upper warning not flagged");
   a_warn_low:
      assert property (temp_above_low [*5] |-> temp_warning_low_n_oe)
      else $error("lower warning not flagged");
   a_ote_latched:
      assert property ((overtemp_error && reset_pin_n) ##1 reset_pin_n [*6]
                       |-> shutdown_fault_n_oe && (temp_warning_high_n_oe || temp_warning_n_oe)
                           && bridge_hiz == 4'hf)
      else $error("overtemperature error not held");
   a_olp_latched:
      assert property ((|overload_fault && reset_pin_n) ##1 reset_pin_n [*6] |-> shutdown_fault_n_oe)
      else $error("overload shutdown not held");
   // ------------------------------------------------------------
   // register bus handshakes
   // ------------------------------------------------------------
   a_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed before taken");
   a_ar_blocked:
      assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while answer pending");
   a_b_once:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
endmodule // amp_fault_reporting_assertions

bind amp_fault_reporting amp_fault_reporting_assertions i_chk (
   .aclk, .aresetn, .reset_pin_n, .gate_drive_supply_ok, .common_supply_ok, .temp_above_low,
   .temp_above_high, .overtemp_error, .overload_fault, .shutdown_fault_n_oe, .temp_warning_low_n_oe,
   .temp_warning_high_n_oe, .temp_warning_n_oe, .bridge_hiz, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
   .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready
);

// file: tb/amp_ctrl_model.sv
// model of the controller that owns the reset pin
`timescale 1ns/1ps
module amp_ctrl_model #(
   parameter int unsigned GAP = 20
) (
   input  wire logic aclk,
   input  wire logic hold_req,
   input  wire logic sd_pin,
   output logic      reset_pin_n
);
   int unsigned since_fall = GAP;
   logic        sd_q       = 1'b1;
   // age of the last shutdown fall, saturating
   always_ff @(posedge aclk) begin
      sd_q <= sd_pin;
      if (sd_q && !sd_pin) since_fall <= 0;
      else if (since_fall < GAP) since_fall <= since_fall + 1;
   end
   // pin starts low; release waits out the gap so thermal recovery is safe
   initial reset_pin_n = 1'b0;
   always @(posedge aclk) begin
      if (hold_req) reset_pin_n <= 1'b0;
      else if (since_fall >= GAP) reset_pin_n <= 1'b1;
   end
endmodule // amp_ctrl_model

// file: tb/amp_fault_reporting_tb.sv
// self-checking bench of the fault-reporting block
`timescale 1ns/1ps
module amp_fault_reporting_tb;
   import amp_fault_pkg::*;
   localparam int unsigned GAP = 20;
   logic        aclk = 0, aresetn = 0, ce = 1, hold_req = 1, reset_pin_n;
   logic        gate_drive_supply_ok = 0, common_supply_ok = 0, overtemp_error = 0;
   logic        temp_above_low = 0, temp_above_high = 0;
   logic [3:0]  overload_fault = 0, s_axi_wstrb = 4'hf, bridge_hiz, bridge_pulldown;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic        shutdown_fault_n_o, shutdown_fault_n_oe, temp_warning_low_n_o, temp_warning_low_n_oe;
   logic        temp_warning_high_n_o, temp_warning_high_n_oe, temp_warning_n_o, temp_warning_n_oe;
   int          err_count = 0, total_checks = 0;
   // pin levels {shutdown, low warning, high warning}: pullup when released
   wire         sd_pin = !shutdown_fault_n_oe;
   wire [2:0]   flags  = {sd_pin, !temp_warning_low_n_oe, !temp_warning_high_n_oe};

   amp_fault_reporting #(.SD_GAP_CYCLES(GAP)) i_dut (
      .aclk, .aresetn, .ce, .reset_pin_n, .gate_drive_supply_ok, .common_supply_ok, .temp_above_low,
      .temp_above_high, .overtemp_error, .overload_fault, .shutdown_fault_n_o, .shutdown_fault_n_oe,
      .temp_warning_low_n_o, .temp_warning_low_n_oe, .temp_warning_high_n_o, .temp_warning_high_n_oe,
      .temp_warning_n_o, .temp_warning_n_oe, .bridge_hiz, .bridge_pulldown, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   amp_ctrl_model #(.GAP(GAP)) i_ctrl (.aclk, .hold_req, .sd_pin, .reset_pin_n);

   always #2.5 aclk = ~aclk;

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // a used-up bound counts as a mismatch and ends the run
   task automatic expire(input logic bad);
      if (bad) begin
         err_count++;
         $display("CHECK FAILED bounded wait expected done seen timeout");
         close_out();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
      s_axi_bready <= 0;
      rr = s_axi_bresp;
      expire(n >= 50);
   endtask
   // read: rready comes late so the answer must wait for it
   task automatic axi_rd(input logic [7:0] a);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
         if (n == 2) s_axi_rready <= 1;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
      s_axi_rready <= 0;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      expire(n >= 50);
   endtask
   task automatic set_mode(input out_mode_e m);
      axi_wr(ADDR_CONTROL, 32'h1 << CTRL_RUN | 32'(m));
      chk("control bresp", rr, RESP_OKAY);
   endtask
   // reset pin pulse through the controller model, checks while low
   task automatic pulse_reset(input logic [3:0] pd);
      int n = 0;
      hold_req <= 1;
      cyc(6);
      chk("flags in reset", flags, 3'b111);
      chk("pulldown in reset", bridge_pulldown, pd);
      hold_req <= 0;
      while (!reset_pin_n && n < 100) begin
         cyc(1);
         n++;
      end
      expire(n >= 100);
      cyc(6);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic s_regs();
      axi_rd(ADDR_CONTROL);
      chk("control reset", rd, CTRL_RESET_VAL);
      axi_rd(8'h0c);
      chk("unmapped rresp", rr, RESP_SLVERR);
      chk("unmapped rdata", rd, 32'h0);
      axi_wr(8'h10, 32'hffff_ffff);
      chk("unmapped bresp", rr, RESP_SLVERR);
      cyc(1); // let bready fall before the next write raises it
   endtask
   // supplies low at power-up, then each dropped and restored alone
   task automatic s_power();
      chk("flags powerup", flags, 3'b111);
      chk("pulldown powerup", bridge_pulldown, 4'hf);
      chk("open drain data", {shutdown_fault_n_o, temp_warning_low_n_o, temp_warning_high_n_o,
                              temp_warning_n_o}, 0);
      set_mode(bridge_tied_mode);
      pulse_reset(4'hf);
      for (int i = 0; i < 2; i++) begin
         {gate_drive_supply_ok, common_supply_ok} <= i ? 2'b10 : 2'b01;
         cyc(6);
         chk("uv flags", flags, 3'b011);
         chk("uv hiz", bridge_hiz, 4'hf);
         {gate_drive_supply_ok, common_supply_ok} <= 2'b11;
         cyc(6);
         chk("uv recover flags", flags, 3'b111);
         chk("uv recover hiz", bridge_hiz, 4'h0);
      end
   endtask
   task automatic s_warn();
      temp_above_low <= 1;
      cyc(6);
      chk("low warn", flags, 3'b101);
      temp_above_high <= 1;
      cyc(6);
      chk("high warn", flags, 3'b100);
      temp_above_low <= 0;
      temp_above_high <= 0;
      cyc(6);
      chk("warn clear", flags, 3'b111);
      // small package: the single flag carries the upper level
      axi_wr(ADDR_CONTROL, 32'h1 << CTRL_RUN | 32'h1 << CTRL_SMALL_PKG);
      temp_above_high <= 1;
      cyc(6);
      chk("single warn", {temp_warning_n_oe, flags}, 4'hf);
      temp_above_high <= 0;
      set_mode(bridge_tied_mode);
      cyc(6);
      chk("single warn clear", temp_warning_n_oe, 1'b0);
   endtask
   // each of the three non-reserved modes and every half-bridge: grouped turn-off, held until reset rises
   task automatic s_olp();
      out_mode_e m;
      for (int k = 0; k < 3; k++) begin
         m = out_mode_e'(k);
         set_mode(m);
         for (int b = 0; b < 4; b++) begin
            overload_fault <= 4'h1 << b;
            cyc(2);
            overload_fault <= 4'h0;
            cyc(8);
            chk("olp flags", flags, 3'b011);
            chk("olp hiz", bridge_hiz, m == parallel_bridge_mode ? 4'hf : (b < 2 ? 4'h3 : 4'hc));
            pulse_reset(m == single_ended_mode ? 4'h0 : 4'hf);
            chk("olp cleared", flags, 3'b111);
            chk("olp hiz cleared", bridge_hiz, 4'h0);
         end
      end
   endtask
   task automatic s_ote();
      set_mode(bridge_tied_mode);
      overtemp_error <= 1;
      cyc(2);
      overtemp_error <= 0;
      cyc(16);
      chk("ote flags", flags, 3'b000);
      chk("ote hiz", bridge_hiz, 4'hf);
      cyc(GAP);
      axi_rd(ADDR_STATUS);
      chk("status ote", rd,
          32'h1 << ST_GAP_DONE | 32'hf << ST_HIZ_LSB | 32'h1 << ST_SHUTDOWN | 32'h1 << ST_OTE_LATCH);
      pulse_reset(4'hf);
      chk("ote cleared", flags, 3'b111);
      chk("ote hiz cleared", bridge_hiz, 4'h0);
   endtask

   initial begin
      cyc(2);
      aresetn <= 1;
      cyc(6);
      s_regs();
      s_power();
      s_warn();
      s_olp();
      s_ote();
      close_out();
   end
endmodule // amp_fault_reporting_tb
